// *** hdl/read_pulse_pkg.sv ***
// constants for the drive read pulse output stage
package read_pulse_pkg;
    localparam int          CLK_MHZ         = 50;
    localparam int          PULSE_WIDTH_US  = 1;
    localparam int          PULSE_CYCLES    = PULSE_WIDTH_US * CLK_MHZ;
    localparam int          WBUSY_HOLD_US   = 900;
    localparam int          WBUSY_CYCLES    = WBUSY_HOLD_US * CLK_MHZ;
    // shortest and longest legal level of the digitized read signal, in cycles
    localparam int          MIN_LEVEL_CYC   = 4;
    localparam int          MAX_LEVEL_CYC   = 400;
    localparam int          CNT_W           = 16;
    localparam int          FIFO_W          = 1;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          WBUSY_W         = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
endpackage

// *** hdl/trig_fifo.sv ***
// small valid/ready fifo carrying validated transition triggers
`timescale 1ns/1ns
`default_nettype none
module trig_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_st_t;
    fifo_st_t s_q, s_d;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_q.cnt != '0;
    assign out_data  = mem[s_q.rp];

    always_comb begin
        s_d = s_q;
        if (push) s_d.wp = s_q.wp + 1'b1;
        if (pop) s_d.rp = s_q.rp + 1'b1;
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce && push) begin
            mem[s_q.wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

// *** hdl/read_pulse_out.sv ***
// read data output stage: validate, edge detect, one-shot, gate
// Behaviour
// - one low pulse per detected transition; a transition during a running pulse extends that pulse instead
// - pulse stays low one microsecond
// - leading edge marks transition position
// - no pulses while unit not selected
// - one-shot enabled only in read state
// - reject read levels outside duty limits
// - edge detector gives single trigger per transition
// - front end ignores input while writing
// - write busy forces output inactive
// - write busy holds 900 us after write
`timescale 1ns/1ns
`default_nettype none
module read_pulse_out
    import read_pulse_pkg::*;
#(
    parameter int WBUSY_HOLD = WBUSY_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic unit_sel,
    input  wire logic write_active,
    input  wire logic write_data_pulse,
    input  wire logic rd_digital,
    output var  logic read_data_n,
    output var  logic write_busy
);
    import read_pulse_pkg::*;

    typedef struct packed {
        logic             rd_prev;
        logic             level;
        logic [CNT_W-1:0] lvl_cnt;
        logic             cand_pend;
        logic [CNT_W-1:0] shot_cnt;
        logic [WBUSY_W-1:0] busy_cnt;
        logic             busy;
        logic             out_n;
    } st_t;
    st_t s_q, s_d;

    logic             raw_edge;
    logic             trig_valid;
    logic             trig_ready;
    logic             fifo_valid;
    logic             fifo_data;
    logic             read_state;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == '1) ? v : v + 1'b1;
    endfunction

    // duty window on the length of the level that just ended; used by the
    // validator and by its checker so both agree on the end points
    function automatic logic level_ok(input logic [CNT_W-1:0] len);
        return len >= CNT_W'(MIN_LEVEL_CYC - 1) && len < CNT_W'(MAX_LEVEL_CYC);
    endfunction

    assign read_state = !s_q.busy && !write_active;
    assign raw_edge   = read_state && (rd_digital != s_q.rd_prev);

    ////////////////////////////////////////////////////////////////////////
    // duty validation: a level change is accepted only when the previous
    // level lasted within limits; a too-short level is a glitch and dropped
    always_comb begin
        s_d = s_q;
        trig_valid = 1'b0;
        // keep following the pin while writing, so the level left by the
        // write is not taken as a fresh transition once reading resumes
        s_d.rd_prev = rd_digital;
        s_d.lvl_cnt = sat_inc(s_q.lvl_cnt);
        if (raw_edge) begin
            s_d.lvl_cnt = CNT_ZERO;
            if (level_ok(s_q.lvl_cnt)) begin
                s_d.cand_pend = 1'b1;
            end
            s_d.level = rd_digital;
        end
        if (s_q.cand_pend) begin
            trig_valid = 1'b1;
            if (trig_ready) s_d.cand_pend = 1'b0;
        end

        // write busy hold after the last write activity; a data pulse alone
        // also restarts the hold, since it may trail the write gate
        if (write_active || write_data_pulse) begin
            s_d.busy     = 1'b1;
            s_d.busy_cnt = WBUSY_W'(WBUSY_HOLD);
        end else if (s_q.busy_cnt != '0) begin
            s_d.busy_cnt = s_q.busy_cnt - 1'b1;
            s_d.busy     = s_q.busy_cnt != WBUSY_W'(1);
        end else begin
            s_d.busy = 1'b0;
        end

        // one-shot, retriggerable, only in read state; a retrigger reloads
        // the full width instead of adding to it, the controller times
        // from the leading edge only
        if (!read_state) begin
            s_d.shot_cnt = CNT_ZERO;
        end else if (fifo_valid && fifo_data) begin
            s_d.shot_cnt = CNT_W'(PULSE_CYCLES);
        end else if (s_q.shot_cnt != CNT_ZERO) begin
            s_d.shot_cnt = s_q.shot_cnt - 1'b1;
        end
        // leading edge follows trigger straight away
        s_d.out_n = !(unit_sel && !s_q.busy && s_d.shot_cnt != CNT_ZERO);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{out_n: 1'b1, default: '0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign read_data_n = s_q.out_n;
    assign write_busy  = s_q.busy;

    ////////////////////////////////////////////////////////////////////////
    // triggers pass a short fifo; drained every cycle so it adds one cycle
    // depth is far above need, room left for a consumer that may stall
    trig_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (trig_valid),
        .in_ready  (trig_ready),
        .in_data   (1'b1),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // output gating: select and write busy win over the one-shot
    AST_NO_SEL: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !unit_sel |=> read_data_n) else $error("pulse while deselected");
    AST_BUSY: assert property (@(posedge ref_clk) disable iff (rst)
        ce && write_busy |=> read_data_n) else $error("pulse while write busy");
    AST_LEAD: assert property (@(posedge ref_clk) disable iff (rst)
        ce && fifo_valid && read_state && unit_sel && !write_busy |=> !read_data_n)
        else $error("leading edge late");
    AST_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
        ce && fifo_valid && read_state && unit_sel && !write_busy
        |=> (!read_data_n || !ce || fifo_valid || !read_state) [*8])
        else $error("pulse too short");

    // one-shot counter: load, count down, idle
    AST_SHOT_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
        ce && fifo_valid && read_state |=> s_q.shot_cnt == CNT_W'(PULSE_CYCLES))
        else $error("one-shot not restarted");
    AST_SHOT_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
        ce && read_state && !fifo_valid && s_q.shot_cnt != CNT_ZERO
        |=> s_q.shot_cnt == $past(s_q.shot_cnt) - CNT_W'(1))
        else $error("one-shot count skipped");
    AST_SHOT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
        ce && read_state && !fifo_valid && s_q.shot_cnt == CNT_ZERO |=> read_data_n)
        else $error("pulse without a running one-shot");
    AST_READ_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !read_state |=> s_q.shot_cnt == CNT_ZERO) else $error("shot outside read");

    // front end: write blocking, duty window, single trigger
    AST_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !read_state && !s_q.cand_pend |=> !s_q.cand_pend)
        else $error("edge taken while writing");
    AST_GLITCH: assert property (@(posedge ref_clk) disable iff (rst)
        ce && raw_edge && !level_ok(s_q.lvl_cnt) && !s_q.cand_pend
        |=> !s_q.cand_pend) else $error("glitch accepted");
    AST_ONE_TRIG: assert property (@(posedge ref_clk) disable iff (rst)
        ce && s_q.cand_pend && trig_ready |=> !s_q.cand_pend || $past(raw_edge))
        else $error("trigger repeated");
    AST_CAND_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        ce && s_q.cand_pend && !trig_ready |=> s_q.cand_pend) else $error("trigger lost");
    AST_FIFO_ROOM: assert property (@(posedge ref_clk) disable iff (rst)
        ce && trig_valid |-> trig_ready) else $error("trigger fifo full");
    AST_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        ce && $rose(s_q.shot_cnt != CNT_ZERO) && unit_sel && !write_busy
        |-> $past(fifo_valid)) else $error("pulse without trigger");

    // write busy: set, hold, release
    AST_BUSY_SET: assert property (@(posedge ref_clk) disable iff (rst)
        ce && write_active |=> write_busy) else $error("busy not set");
    AST_WDP: assert property (@(posedge ref_clk) disable iff (rst)
        ce && write_data_pulse |=> write_busy && s_q.busy_cnt == WBUSY_W'(WBUSY_HOLD))
        else $error("data pulse did not restart hold");
    AST_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !write_active && !write_data_pulse && s_q.busy_cnt > WBUSY_W'(1)
        |=> write_busy) else $error("busy dropped early");
    AST_BUSY_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !write_active && !write_data_pulse && s_q.busy_cnt == WBUSY_W'(1)
        |=> !write_busy) else $error("busy held too long");

    // clock enable low freezes the output with all other state
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
        !ce |=> $stable(read_data_n)) else $error("output moved while frozen");

    COV_PULSE: cover property (@(posedge ref_clk) $fell(read_data_n));
    COV_RETRIG: cover property (@(posedge ref_clk) !read_data_n && fifo_valid);
    COV_BUSY_END: cover property (@(posedge ref_clk) $fell(write_busy));
    COV_GLITCH: cover property (@(posedge ref_clk) ce && raw_edge && !level_ok(s_q.lvl_cnt));
    COV_FREEZE: cover property (@(posedge ref_clk) !ce && !read_data_n);
endmodule
`default_nettype wire

// *** sim/pulse_rx_model.sv ***
// controller side model: counts read pulses and measures their low width
`timescale 1ns/1ns
`default_nettype none
module pulse_rx_model (
    input  wire logic ref_clk,
    input  wire logic read_data_n,
    output var  int   n_pulses,
    output var  int   last_w
);
    logic prev_n = 1'b1;
    int   low_w  = 0;

    initial begin
        n_pulses = 0;
        last_w   = 0;
    end

    always @(posedge ref_clk) begin
        prev_n <= read_data_n;
        // a pulse is counted at its falling edge; its low width is closed at the rising edge
        if (prev_n === 1'b1 && read_data_n === 1'b0) begin
            n_pulses <= n_pulses + 1;
        end
        if (read_data_n === 1'b0) begin
            low_w <= low_w + 1;
        end else if (prev_n === 1'b0) begin
            last_w <= low_w;
            low_w  <= 0;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_drive_read_pulse_output.sv ***
// testbench for the read pulse output stage
`timescale 1ns/1ns
`default_nettype none
module tb_drive_read_pulse_output;
    logic ref_clk, rst, ce, unit_sel, write_active, write_data_pulse, rd_digital;
    logic read_data_n, write_busy;
    int   n_pulses, last_w, num_errors, check_count, base;

    // short write hold keeps the run brief
    read_pulse_out #(.WBUSY_HOLD(20)) read_pulse_out_inst (.ref_clk(ref_clk), .rst(rst),
        .ce(ce), .unit_sel(unit_sel), .write_active(write_active),
        .write_data_pulse(write_data_pulse), .rd_digital(rd_digital),
        .read_data_n(read_data_n), .write_busy(write_busy));
    pulse_rx_model pulse_rx_model_inst (.ref_clk(ref_clk), .read_data_n(read_data_n),
        .n_pulses(n_pulses), .last_w(last_w));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk_n(input string what, input int exp, input int got);
        #1;
        check_count++;
        if (exp != got) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic chk_l(input string what, input logic exp, input logic got);
        #1;
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic t_single();
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            base = n_pulses;
            rd_digital <= ~rd_digital;
            cyc(5);
            chk_l("read_data_n", 1'b0, read_data_n);
            cyc(60);
            chk_n("pulse count", base + 1, n_pulses);
            chk_n("pulse width", 50, last_w);
        end
        $display("done single pulses");
    endtask

    task automatic t_retrig();
        cyc(1);
        base = n_pulses;
        rd_digital <= ~rd_digital;
        cyc(10);
        rd_digital <= ~rd_digital;
        cyc(70);
        chk_n("pulse count", base + 1, n_pulses);
        chk_n("pulse width", 60, last_w);
        $display("done retrigger");
    endtask

    task automatic t_unsel();
        cyc(1);
        base = n_pulses;
        unit_sel <= 1'b0;
        rd_digital <= ~rd_digital;
        cyc(5);
        chk_l("read_data_n", 1'b1, read_data_n);
        cyc(60);
        chk_n("pulse count", base, n_pulses);
        cyc(1);
        unit_sel <= 1'b1;
        $display("done unit select");
    endtask

    task automatic t_freeze();
        cyc(1);
        base = n_pulses;
        rd_digital <= ~rd_digital;
        cyc(10);
        ce <= 1'b0;
        cyc(10);
        chk_l("read_data_n", 1'b0, read_data_n);
        cyc(10);
        ce <= 1'b1;
        cyc(70);
        chk_n("pulse count", base + 1, n_pulses);
        chk_n("pulse width", 70, last_w);
        $display("done clock enable freeze");
    endtask

    task automatic t_wpulse();
        cyc(1);
        write_data_pulse <= 1'b1;
        cyc(1);
        write_data_pulse <= 1'b0;
        cyc(2);
        chk_l("write_busy", 1'b1, write_busy);
        cyc(25);
        chk_l("write_busy", 1'b0, write_busy);
        $display("done write data pulse");
    endtask

    task automatic t_duty();
        cyc(1);
        base = n_pulses;
        rd_digital <= ~rd_digital;
        cyc(2);
        rd_digital <= ~rd_digital;
        cyc(70);
        chk_n("pulse count", base + 1, n_pulses);
        chk_n("pulse width", 50, last_w);
        cyc(450);
        rd_digital <= ~rd_digital;
        cyc(70);
        chk_n("pulse count", base + 1, n_pulses);
        $display("done duty window");
    endtask

    task automatic t_write();
        cyc(1);
        base = n_pulses;
        write_active <= 1'b1;
        write_data_pulse <= 1'b1;
        cyc(2);
        write_data_pulse <= 1'b0;
        rd_digital <= ~rd_digital;
        cyc(5);
        chk_l("write_busy", 1'b1, write_busy);
        chk_l("read_data_n", 1'b1, read_data_n);
        cyc(1);
        write_active <= 1'b0;
        cyc(15);
        chk_l("write_busy", 1'b1, write_busy);
        cyc(12);
        chk_l("write_busy", 1'b0, write_busy);
        chk_n("pulse count", base, n_pulses);
        $display("done write busy");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        unit_sel = 1'b1;
        write_active = 1'b0;
        write_data_pulse = 1'b0;
        rd_digital = 1'b0;
        num_errors = 0;
        check_count = 0;
        cyc(20);
        rst <= 1'b0;
        cyc(10);
        t_single();
        t_retrig();
        t_freeze();
        t_unsel();
        t_duty();
        t_write();
        t_wpulse();
        print_verdict();
    end
endmodule
`default_nettype wire
